//--- core/pmb_bridge.sv
// profile-steered bridge data paths, reset and clock handling, integrated arbiter
`timescale 1ns/100ps
module pmb_bridge (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          nrst,
	// static configuration
	input  wire pmb_pkg::pmb_tprof_t           tgt_profile,
	input  wire logic                          mst_multi_pend,
	input  wire pmb_pkg::pmb_mode_t            dev_mode,
	input  wire logic                          arb_enable,
	input  wire logic                          shared_clock,
	input  wire logic                          indep_reset_enable,
	// pins: pci clock and interconnect reset
	input  wire logic                          pci_clk_in,
	input  wire logic                          ic_reset_n_in,
	output logic                               periph_reset_n,
	// pci target requests
	input  wire logic                          t_req_valid,
	input  wire logic                          t_req_write,
	input  wire logic                          t_req_pref,
	input  wire logic [pmb_pkg::ADDR_W-1:0]    t_req_addr,
	input  wire logic [pmb_pkg::DATA_W-1:0]    t_req_wdata,
	output logic                               t_ack,
	output logic                               t_retry,
	output logic [pmb_pkg::DATA_W-1:0]         t_rdata,
	// non-prefetchable interconnect master
	output logic                               np_valid,
	output logic                               np_write,
	output logic [pmb_pkg::ADDR_W-1:0]         np_addr,
	output logic [pmb_pkg::DATA_W-1:0]         np_wdata,
	input  wire logic                          np_ready,
	input  wire logic                          np_rvalid,
	input  wire logic [pmb_pkg::DATA_W-1:0]    np_rdata,
	// prefetchable interconnect master
	output logic                               pf_valid,
	output logic                               pf_write,
	output logic [pmb_pkg::ADDR_W-1:0]         pf_addr,
	output logic [pmb_pkg::DATA_W-1:0]         pf_wdata,
	input  wire logic                          pf_ready,
	input  wire logic                          pf_rvalid,
	input  wire logic [pmb_pkg::DATA_W-1:0]    pf_rdata,
	// interconnect slave towards pci
	input  wire logic                          ms_valid,
	input  wire logic                          ms_write,
	input  wire logic [pmb_pkg::ADDR_W-1:0]    ms_addr,
	input  wire logic [pmb_pkg::DATA_W-1:0]    ms_wdata,
	output logic                               ms_ready,
	output logic                               ms_rvalid,
	output logic [pmb_pkg::DATA_W-1:0]         ms_rdata,
	// pci master side
	output logic                               pm_valid,
	output logic                               pm_write,
	output logic [pmb_pkg::ADDR_W-1:0]         pm_addr,
	output logic [pmb_pkg::DATA_W-1:0]         pm_wdata,
	input  wire logic                          pm_ready,
	input  wire logic                          pm_rvalid,
	input  wire logic [pmb_pkg::DATA_W-1:0]    pm_rdata,
	// arbiter pins
	input  wire logic [pmb_pkg::AGENTS-1:0]    agent_bus_request_n_in,
	output logic [pmb_pkg::AGENTS-1:0]         agent_bus_grant_n_out
);
	localparam int NA = pmb_pkg::AGENTS;
	localparam int NP = pmb_pkg::PEND_SLOTS;

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// ----------------------------------------------------------------
	// pin synchronisers and pci clock edge
	// ----------------------------------------------------------------
	logic          pclk_meta_ff, pclk_sync_ff, pclk_prev_ff;
	logic          icr_meta_ff, icr_sync_ff;
	logic [NA-1:0] req_meta_ff, req_sync_ff;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			{pclk_meta_ff, pclk_sync_ff, pclk_prev_ff} <= 3'h0;
			{icr_meta_ff, icr_sync_ff}                 <= 2'h0;
			req_meta_ff                                <= '1;
			req_sync_ff                                <= '1;
		end
		else
		begin
			pclk_meta_ff <= pci_clk_in;
			pclk_sync_ff <= pclk_meta_ff;
			pclk_prev_ff <= pclk_sync_ff;
			icr_meta_ff  <= ic_reset_n_in;
			icr_sync_ff  <= icr_meta_ff;
			req_meta_ff  <= agent_bus_request_n_in;
			req_sync_ff  <= req_meta_ff;
		end
	end
	// pci-side work steps on every clk when shared, else on each pci clock rise
	wire pci_tick = shared_clock | (pclk_sync_ff & ~pclk_prev_ff);

	// ----------------------------------------------------------------
	// resets
	// ----------------------------------------------------------------
	logic periph_rst_ff;
	// bridge state never sees ic_reset_n_in, only the rest of the system does
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			periph_rst_ff <= 1'b0;
		else
			periph_rst_ff <= indep_reset_enable ? icr_sync_ff : 1'b1;
	end
	assign periph_reset_n = periph_rst_ff;
	a_periph_reset: assert property (!indep_reset_enable |=> periph_reset_n)
		else $error("peripheral reset held while option off");

	// ----------------------------------------------------------------
	// target decode and pending read limit
	// ----------------------------------------------------------------
	pmb_stream_if #(pmb_pkg::CMD_W) tf_in ();
	pmb_stream_if #(pmb_pkg::CMD_W) tf_out ();
	pmb_pkg::pmb_np_t           np_st_ff;
	logic                       np_wr_ff;
	logic [pmb_pkg::ADDR_W-1:0] np_addr_ff;
	logic [pmb_pkg::DATA_W-1:0] np_wdata_ff, np_rdata_ff;
	pmb_pkg::pmb_pe_t           pe_st_ff [NP];
	logic [pmb_pkg::ADDR_W-1:0] pe_addr_ff [NP];
	logic [pmb_pkg::DATA_W-1:0] pe_data_ff [NP];
	logic [1:0]                 alloc_ptr_ff, resp_ptr_ff;
	logic                       pe_hit, pe_hit_rdy;
	logic [1:0]                 pe_hit_idx;
	logic [2:0]                 pf_cnt;

	wire t_go    = pci_tick & t_req_valid;
	wire burst   = (tgt_profile != pmb_pkg::TP_SINGLE);
	wire to_pf   = t_req_pref & burst;
	wire [2:0] t_limit = (tgt_profile == pmb_pkg::TP_BURST_MULTI) ?
		pmb_pkg::LIMIT_MULTI : pmb_pkg::LIMIT_ONE;
	wire np_rd_busy = ~np_wr_ff & (np_st_ff != pmb_pkg::NP_IDLE);
	wire [2:0] rd_pend = pf_cnt + {2'h0, np_rd_busy};
	wire room    = (rd_pend < t_limit);

	always_comb
	begin
		pe_hit     = 1'b0;
		pe_hit_rdy = 1'b0;
		pe_hit_idx = 2'h0;
		pf_cnt     = 3'h0;
		for (int i = 0; i < NP; i++)
		begin
			if (pe_st_ff[i] != pmb_pkg::PE_FREE)
			begin
				pf_cnt = pf_cnt + 3'h1;
				if (pe_addr_ff[i] == t_req_addr)
				begin
					pe_hit     = 1'b1;
					pe_hit_rdy = (pe_st_ff[i] == pmb_pkg::PE_READY);
					pe_hit_idx = 2'(i);
				end
			end
		end
	end

	// prefetchable path: writes and read requests enter the buffer
	wire pf_wr_go   = t_go & to_pf & t_req_write & tf_in.ready;
	wire pf_rd_done = t_go & to_pf & ~t_req_write & pe_hit_rdy;
	wire pf_alloc   = t_go & to_pf & ~t_req_write & ~pe_hit & room & tf_in.ready
		& (pe_st_ff[alloc_ptr_ff] == pmb_pkg::PE_FREE);
	wire tf_push    = pf_wr_go | pf_alloc;
	assign tf_in.valid = tf_push;
	assign tf_in.data  = {t_req_write, t_req_addr, t_req_write ? t_req_wdata : '0};

	// non-prefetchable path: one command register
	wire np_free    = (np_st_ff == pmb_pkg::NP_IDLE);
	wire np_wr_go   = t_go & ~to_pf & t_req_write & np_free;
	wire np_rd_go   = t_go & ~to_pf & ~t_req_write & np_free & room;
	wire np_rd_done = t_go & ~to_pf & ~t_req_write & (np_st_ff == pmb_pkg::NP_DONE)
		& (np_addr_ff == t_req_addr);
	wire t_ok       = pf_wr_go | pf_rd_done | np_wr_go | np_rd_done;

	// ----------------------------------------------------------------
	// target answers and pending table
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			t_ack        <= 1'b0;
			t_retry      <= 1'b0;
			t_rdata      <= '0;
			alloc_ptr_ff <= 2'h0;
			resp_ptr_ff  <= 2'h0;
			for (int i = 0; i < NP; i++)
			begin
				pe_st_ff[i]   <= pmb_pkg::PE_FREE;
				pe_addr_ff[i] <= '0;
				pe_data_ff[i] <= '0;
			end
		end
		else
		begin
			t_ack   <= t_ok;
			t_retry <= t_go & ~t_ok;
			if (pf_rd_done)
				t_rdata <= pe_data_ff[pe_hit_idx];
			else if (np_rd_done)
				t_rdata <= np_rdata_ff;
			if (pf_alloc)
			begin
				pe_st_ff[alloc_ptr_ff]   <= pmb_pkg::PE_ISSUED;
				pe_addr_ff[alloc_ptr_ff] <= t_req_addr;
				alloc_ptr_ff             <= alloc_ptr_ff + 2'h1;
			end
			// read data returns in issue order on the prefetchable port
			if (pf_rvalid)
			begin
				pe_st_ff[resp_ptr_ff]   <= pmb_pkg::PE_READY;
				pe_data_ff[resp_ptr_ff] <= pf_rdata;
				resp_ptr_ff             <= resp_ptr_ff + 2'h1;
			end
			if (pf_rd_done)
				pe_st_ff[pe_hit_idx] <= pmb_pkg::PE_FREE;
		end
	end

	pmb_fifo #(.W(pmb_pkg::CMD_W), .D(pmb_pkg::FIFO_DEPTH)) u_tgt_buf (
		.clk   (clk),
		.nrst  (nrst),
		.in_s  (tf_in),
		.out_s (tf_out)
	);
	assign pf_valid     = tf_out.valid;
	assign tf_out.ready = pf_ready;
	assign pf_write     = tf_out.data[pmb_pkg::CMD_WR_BIT];
	assign pf_addr      = tf_out.data[pmb_pkg::CMD_A_LSB +: pmb_pkg::ADDR_W];
	assign pf_wdata     = tf_out.data[pmb_pkg::DATA_W-1:0];

	// ----------------------------------------------------------------
	// non-prefetchable command register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			np_st_ff    <= pmb_pkg::NP_IDLE;
			np_wr_ff    <= 1'b0;
			np_addr_ff  <= '0;
			np_wdata_ff <= '0;
			np_rdata_ff <= '0;
		end
		else
		begin
			case (np_st_ff)
				pmb_pkg::NP_IDLE:
					if (np_wr_go | np_rd_go)
					begin
						np_st_ff    <= pmb_pkg::NP_ISSUE;
						np_wr_ff    <= t_req_write;
						np_addr_ff  <= t_req_addr;
						np_wdata_ff <= t_req_wdata;
					end
				pmb_pkg::NP_ISSUE:
					if (np_ready)
						np_st_ff <= np_wr_ff ? pmb_pkg::NP_IDLE : pmb_pkg::NP_WAIT;
				pmb_pkg::NP_WAIT:
					if (np_rvalid)
					begin
						np_st_ff    <= pmb_pkg::NP_DONE;
						np_rdata_ff <= np_rdata;
					end
				pmb_pkg::NP_DONE:
					if (np_rd_done)
						np_st_ff <= pmb_pkg::NP_IDLE;
				default:
					np_st_ff <= pmb_pkg::NP_IDLE;
			endcase
		end
	end
	assign np_valid = (np_st_ff == pmb_pkg::NP_ISSUE);
	assign np_write = np_wr_ff;
	assign np_addr  = np_addr_ff;
	assign np_wdata = np_wdata_ff;

	a_single_nobuf: assert property ((tgt_profile == pmb_pkg::TP_SINGLE) |-> !tf_push)
		else $error("buffer used in single-cycle profile");
	a_np_route: assert property ((t_go && !t_req_pref) |-> !tf_push)
		else $error("non-prefetchable hit sent to buffer");
	a_read_limit: assert property (rd_pend <= t_limit)
		else $error("too many delayed reads pending");
	a_first_retry: assert property ((pf_alloc || np_rd_go) |=> t_retry && !t_ack)
		else $error("new delayed read not retried");

	// ----------------------------------------------------------------
	// master path: interconnect to pci
	// ----------------------------------------------------------------
	pmb_stream_if #(pmb_pkg::CMD_W) mf_in ();
	pmb_stream_if #(pmb_pkg::CMD_W) mf_out ();
	logic [NA-1:0] grant_ff;
	logic [1:0]    last_ff;
	logic [2:0]    mo_cnt_ff;

	// host-bridge and master/target modes share one master behaviour
	wire master_on = (dev_mode == pmb_pkg::MODE_MASTER) | (dev_mode == pmb_pkg::MODE_HOST);
	wire [2:0] m_limit = mst_multi_pend ? pmb_pkg::LIMIT_MULTI : pmb_pkg::LIMIT_ONE;
	wire m_is_wr   = mf_out.data[pmb_pkg::CMD_WR_BIT];
	wire own_req   = master_on & mf_out.valid & (m_is_wr | (mo_cnt_ff < m_limit));
	wire granted0  = arb_enable ? grant_ff[0] : 1'b1;
	wire pm_go     = pm_valid & pm_ready;

	assign mf_in.valid  = ms_valid & master_on;
	assign mf_in.data   = {ms_write, ms_addr, ms_wdata};
	assign ms_ready     = mf_in.ready & master_on;
	assign pm_valid     = own_req & granted0 & pci_tick;
	assign mf_out.ready = pm_go;
	assign pm_write     = m_is_wr;
	assign pm_addr      = mf_out.data[pmb_pkg::CMD_A_LSB +: pmb_pkg::ADDR_W];
	assign pm_wdata     = mf_out.data[pmb_pkg::DATA_W-1:0];

	pmb_fifo #(.W(pmb_pkg::CMD_W), .D(pmb_pkg::FIFO_DEPTH)) u_mst_buf (
		.clk   (clk),
		.nrst  (nrst),
		.in_s  (mf_in),
		.out_s (mf_out)
	);

	// reads are answered later through ms_rvalid, not by holding ms_ready
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			mo_cnt_ff <= 3'h0;
			ms_rvalid <= 1'b0;
			ms_rdata  <= '0;
		end
		else
		begin
			mo_cnt_ff <= mo_cnt_ff + {2'h0, pm_go & ~m_is_wr} - {2'h0, pm_rvalid & (mo_cnt_ff != 3'h0)};
			ms_rvalid <= pm_rvalid;
			if (pm_rvalid)
				ms_rdata <= pm_rdata;
		end
	end

	a_master_off: assert property (!master_on |-> !ms_ready && !pm_valid)
		else $error("master path active in target-only mode");
	a_mst_pending: assert property (mo_cnt_ff <= m_limit)
		else $error("too many master reads outstanding");

	// ----------------------------------------------------------------
	// integrated arbiter, round robin
	// ----------------------------------------------------------------
	function automatic logic [NA-1:0] rr_pick(input logic [NA-1:0] req, input logic [1:0] last);
		logic [NA-1:0] g;
		logic [1:0]    idx;
		g = '0;
		for (int k = NA; k >= 1; k--)
		begin
			idx = last + 2'(k);
			if (req[idx])
				g = NA'(1) << idx;
		end
		return g;
	endfunction

	// agent zero's request pin is replaced by the bridge's own master
	wire [NA-1:0] arb_req = {~req_sync_ff[NA-1:1], own_req};
	wire [NA-1:0] nxt_grant = |(grant_ff & arb_req) ? grant_ff : rr_pick(arb_req, last_ff);

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			grant_ff <= '0;
			last_ff  <= 2'h0;
		end
		else if (!arb_enable)
			grant_ff <= '0;
		else if (pci_tick)
		begin
			grant_ff <= nxt_grant;
			for (int k = 0; k < NA; k++)
				if (nxt_grant[k])
					last_ff <= 2'(k);
		end
	end
	assign agent_bus_grant_n_out = ~grant_ff;

	a_grant_onehot: assert property ($onehot0(grant_ff))
		else $error("more than one grant");
	a_grant_to_req: assert property ((grant_ff != '0 && $changed(grant_ff)) |-> |(grant_ff & $past(arb_req)))
		else $error("grant given without request");
	a_grant_off: assert property (!arb_enable |=> agent_bus_grant_n_out == '1)
		else $error("grant driven with arbiter disabled");
	a_own_grant: assert property ((arb_enable && pm_valid) |-> !agent_bus_grant_n_out[0])
		else $error("own master issued without agent zero grant");
endmodule // pmb_bridge

//--- core/pmb_fifo.sv
// dual-port command buffer with valid/ready on both sides
`timescale 1ns/100ps
module pmb_fifo #(
	parameter int W = pmb_pkg::CMD_W,
	parameter int D = pmb_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// fill side
	pmb_stream_if.snk in_s,
	// drain side
	pmb_stream_if.src out_s
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0]   cnt_ff;
	wire push = in_s.valid & in_s.ready;
	wire pop  = out_s.valid & out_s.ready;
	wire full = (cnt_ff == (AW+1)'(D));

	assign in_s.ready  = ~full;
	assign out_s.valid = (cnt_ff != '0);
	assign out_s.data  = mem[rd_ptr_ff];

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr_ff] <= in_s.data;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff    <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_ff <= (wr_ptr_ff == AW'(D-1)) ? '0 : wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= (rd_ptr_ff == AW'(D-1)) ? '0 : rd_ptr_ff + 1'b1;
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	a_fifo_bounds: assert property (@(posedge clk) disable iff (!nrst)
		(push && !pop) |=> (cnt_ff == $past(cnt_ff) + 1'b1) && (cnt_ff <= (AW+1)'(D)))
		else $error("buffer count wrong after push");
endmodule // pmb_fifo

//--- core/pmb_pkg.sv
// shared constants and types of the bridge profile and arbiter block
package pmb_pkg;
	// ----------------------------------------------------------------
	// widths and sizes
	// ----------------------------------------------------------------
	localparam int ADDR_W     = 32;
	localparam int DATA_W     = 32;
	localparam int CMD_W      = 1 + ADDR_W + DATA_W;
	localparam int FIFO_DEPTH = 8;
	localparam int AGENTS     = 4;
	localparam int PEND_SLOTS = 4;
	localparam int SYNC_RST   = 1;
	// ----------------------------------------------------------------
	// command word layout: {write, addr, data}
	// ----------------------------------------------------------------
	localparam int CMD_WR_BIT = CMD_W - 1;
	localparam int CMD_A_LSB  = DATA_W;
	// ----------------------------------------------------------------
	// pending read limits and clock
	// ----------------------------------------------------------------
	localparam logic [2:0] LIMIT_ONE   = 3'h1;
	localparam logic [2:0] LIMIT_MULTI = 3'h4;
	localparam int CLK_PERIOD_NS = 5;
	// ----------------------------------------------------------------
	// enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		TP_SINGLE      = 2'h0,
		TP_BURST_ONE   = 2'h1,
		TP_BURST_MULTI = 2'h2
	} pmb_tprof_t;
	typedef enum logic [1:0] {
		MODE_TARGET = 2'h0,
		MODE_MASTER = 2'h1,
		MODE_HOST   = 2'h2
	} pmb_mode_t;
	typedef enum logic [1:0] {
		NP_IDLE  = 2'h0,
		NP_ISSUE = 2'h1,
		NP_WAIT  = 2'h2,
		NP_DONE  = 2'h3
	} pmb_np_t;
	typedef enum logic [1:0] {
		PE_FREE   = 2'h0,
		PE_ISSUED = 2'h1,
		PE_READY  = 2'h2
	} pmb_pe_t;
endpackage

//--- core/pmb_stream_if.sv
// valid/ready stream carrying command words between the bridge and its buffers
`timescale 1ns/100ps
interface pmb_stream_if #(parameter int W = pmb_pkg::CMD_W);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface // pmb_stream_if

//--- sim/pmb_far_slave.sv
// far-side model: a slave answering one valid/ready port, reads in issue order
`timescale 1ns/100ps
module pmb_far_slave (
	// clock, reset and pacing
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        blk,
	input  wire logic        slow,
	// request port
	input  wire logic        valid,
	input  wire logic        write,
	input  wire logic [31:0] addr,
	output logic             ready,
	output logic             rvalid,
	output logic [31:0]      rdata
);
	// ----------------
	// responses
	// ----------------
	logic [31:0] q[$];
	logic        go;
	assign ready = !blk;
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			q.delete();
		else if (valid && ready && !write)
			q.push_back(addr);
		go = nrst && !slow && q.size() != 0;
		rvalid <= go;
		// idle data flips every cycle so a stale word cannot pass
		rdata  <= go ? q.pop_front() ^ 32'hA5A5_0F0F : (nrst ? ~rdata : 32'h0);
	end
endmodule // pmb_far_slave

//--- sim/test_pmb_bridge.sv
// self-checking bench of the bridge: profiles, resets, clocks, buffering, arbiter
`timescale 1ns/100ps
module test_pmb_bridge;
	// ----------------
	// signals and parts
	// ----------------
	logic                clk, nrst, mst_multi_pend, arb_enable, shared_clock, indep_reset_enable, ok;
	logic                pci_clk_in, pclk_run, ic_reset_n_in, periph_reset_n, pm_blk, pm_slow, pf_slow;
	pmb_pkg::pmb_tprof_t tgt_profile;
	pmb_pkg::pmb_mode_t  dev_mode;
	logic                t_req_valid, t_req_write, t_req_pref, t_ack, t_retry, np_valid, np_write, np_ready;
	logic                np_rvalid, pf_valid, pf_write, pf_ready, pf_rvalid, ms_valid, ms_write, ms_ready;
	logic                ms_rvalid, pm_valid, pm_write, pm_ready, pm_rvalid;
	logic [31:0]         t_req_addr, t_req_wdata, t_rdata, np_addr, np_wdata, np_rdata, pf_addr, pf_wdata;
	logic [31:0]         pf_rdata, ms_addr, ms_wdata, ms_rdata, pm_addr, pm_wdata, pm_rdata, last_np, last_pf;
	logic [31:0]         last_pm;
	logic [3:0]          agent_bus_request_n_in, agent_bus_grant_n_out;
	int                  num_errors = 0, n_compared = 0, n_pf = 0, n_pm = 0, n_msr = 0, outst = 0, max_out = 0;
	int                  i, b, na;
	pmb_bridge i_pmb_bridge (.clk, .nrst, .tgt_profile, .mst_multi_pend, .dev_mode, .arb_enable, .shared_clock,
		.indep_reset_enable, .pci_clk_in, .ic_reset_n_in, .periph_reset_n, .t_req_valid, .t_req_write, .t_req_pref,
		.t_req_addr, .t_req_wdata, .t_ack, .t_retry, .t_rdata, .np_valid, .np_write, .np_addr, .np_wdata, .np_ready,
		.np_rvalid, .np_rdata, .pf_valid, .pf_write, .pf_addr, .pf_wdata, .pf_ready, .pf_rvalid, .pf_rdata,
		.ms_valid, .ms_write, .ms_addr, .ms_wdata, .ms_ready, .ms_rvalid, .ms_rdata, .pm_valid, .pm_write,
		.pm_addr, .pm_wdata, .pm_ready, .pm_rvalid, .pm_rdata, .agent_bus_request_n_in, .agent_bus_grant_n_out);
	pmb_far_slave far_np (.clk, .nrst, .blk(1'h0), .slow(1'h0), .valid(np_valid), .write(np_write),
		.addr(np_addr), .ready(np_ready), .rvalid(np_rvalid), .rdata(np_rdata));
	pmb_far_slave far_pf (.clk, .nrst, .blk(1'h0), .slow(pf_slow), .valid(pf_valid), .write(pf_write),
		.addr(pf_addr), .ready(pf_ready), .rvalid(pf_rvalid), .rdata(pf_rdata));
	pmb_far_slave far_pm (.clk, .nrst, .blk(pm_blk), .slow(pm_slow), .valid(pm_valid), .write(pm_write),
		.addr(pm_addr), .ready(pm_ready), .rvalid(pm_rvalid), .rdata(pm_rdata));
	initial
	begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	always #32 pci_clk_in = pclk_run ? ~pci_clk_in : pci_clk_in;
	// ----------------
	// tasks and monitor
	// ----------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic rst(input pmb_pkg::pmb_tprof_t tp, input pmb_pkg::pmb_mode_t md, input logic mp, ab, sh);
		@(posedge clk);
		nrst           <= 1'h0; // bench reset plays the pci bus reset
		tgt_profile    <= tp;
		dev_mode       <= md;
		mst_multi_pend <= mp;
		arb_enable     <= ab;
		shared_clock   <= sh;
		indep_reset_enable <= sh; // option switched off only in the split-clock run
		pclk_run       <= !sh; // one clock only when shared
		repeat (4) @(posedge clk);
		chk("gnt_in_rst", agent_bus_grant_n_out, 4'hF);
		chk("prst_in_rst", periph_reset_n, 1'h0);
		nrst <= 1'h1;
		repeat (6) @(posedge clk);
	endtask
	task automatic tgt(input logic w, p, input logic [31:0] a, output logic acc);
		@(posedge clk);
		t_req_valid <= 1'h1;
		t_req_write <= w;
		t_req_pref  <= p;
		t_req_addr  <= a;
		t_req_wdata <= ~a;
		// shared clock takes it at once; otherwise hold until answered
		for (int k = 0; k < 200; k++)
		begin
			@(posedge clk);
			if (shared_clock)
				t_req_valid <= 1'h0;
			#1;
			if (t_ack || t_retry)
				break;
		end
		acc = t_ack;
		if (!shared_clock)
			@(posedge clk) t_req_valid <= 1'h0;
	endtask
	task automatic rd(input logic p, f, input logic [31:0] a);
		logic acc;
		tgt(1'h0, p, a, acc);
		if (f)
			chk("rd_first", acc, 1'h0);
		for (int k = 0; k < 40 && !acc; k++)
			tgt(1'h0, p, a, acc);
		chk("rd_done", acc, 1'h1);
		chk("rd_data", t_rdata, a ^ 32'hA5A5_0F0F);
	endtask
	task automatic mst(input logic w, input logic [31:0] a, output logic acc);
		int k = 0;
		@(posedge clk);
		ms_valid <= 1'h1;
		ms_write <= w;
		ms_addr  <= a;
		ms_wdata <= ~a;
		do
			@(negedge clk);
		while (!ms_ready && ++k < 200);
		acc = ms_ready;
		@(posedge clk);
		ms_valid <= 1'h0;
	endtask
	task automatic mrd(input int n, input int lim);
		logic acc;
		int   b0;
		b0 = n_msr;
		pm_slow <= 1'h1;
		for (int k = 0; k < n; k++)
			mst(1'h0, 32'h0000_1000 + k, acc);
		repeat (30) @(posedge clk);
		chk("max_outst", max_out, lim);
		pm_slow <= 1'h0;
		repeat (60) @(posedge clk);
		chk("ms_rd_cnt", n_msr - b0, n);
		chk("ms_rd_last", ms_rdata, (32'h0000_0FFF + n) ^ 32'hA5A5_0F0F);
	endtask
	always @(posedge clk)
	begin
		if (np_valid && np_ready)
			last_np <= np_addr;
		if (pf_valid && pf_ready)
			last_pf <= pf_addr;
		if (pm_valid && pm_ready)
			last_pm <= pm_addr;
		if (np_valid && np_ready && np_write)
			chk("np_wdata", np_wdata, ~np_addr);
		if (pf_valid && pf_ready && pf_write)
			chk("pf_wdata", pf_wdata, ~pf_addr);
		if (pm_valid && pm_ready && pm_write)
			chk("pm_wdata", pm_wdata, ~pm_addr);
		n_pf    <= n_pf + (pf_valid && pf_ready);
		n_pm    <= n_pm + (pm_valid && pm_ready);
		n_msr   <= n_msr + ms_rvalid;
		outst   <= outst + (pm_valid && pm_ready && !pm_write) - pm_rvalid;
		max_out <= !pm_slow ? 0 : (outst > max_out ? outst : max_out);
		if (pm_valid && arb_enable)
			chk("own_gnt", agent_bus_grant_n_out[0], 1'h0);
		if (arb_enable && nrst)
			chk("gnt_onehot", $countones(~agent_bus_grant_n_out) <= 1, 1'h1);
	end
	// ----------------
	// sequence
	// ----------------
	initial
	begin
		{nrst, pci_clk_in, ic_reset_n_in, pm_blk, pm_slow, pf_slow, pclk_run, mst_multi_pend} = '0;
		{t_req_valid, t_req_write, t_req_pref, ms_valid, ms_write, arb_enable, shared_clock} = '0;
		{t_req_addr, t_req_wdata, ms_addr, ms_wdata} = '0;
		indep_reset_enable = 1'h1;
		agent_bus_request_n_in = 4'hF;
		tgt_profile = pmb_pkg::TP_SINGLE;
		dev_mode = pmb_pkg::MODE_TARGET;
		rst(pmb_pkg::TP_SINGLE, pmb_pkg::MODE_TARGET, 1'h0, 1'h0, 1'h1);
		chk("prst_hold", periph_reset_n, 1'h0);
		ic_reset_n_in <= 1'h1;
		repeat (8) @(posedge clk);
		chk("prst_free", periph_reset_n, 1'h1);
		chk("ms_rdy_tgt", ms_ready, 1'h0);
		b = n_pf;
		tgt(1'h1, 1'h1, 32'h0000_0100, ok);
		chk("np_wr_ack", ok, 1'h1);
		repeat (4) @(posedge clk);
		chk("np_wr_addr", last_np, 32'h0000_0100);
		rd(1'h1, 1'h1, 32'h0000_0200);
		chk("no_pf_use", n_pf - b, 0);
		agent_bus_request_n_in <= 4'hB; // agent two asks for the bus
		repeat (12) @(posedge clk);
		chk("gnt_off", agent_bus_grant_n_out, 4'hF);
		agent_bus_request_n_in <= 4'hF;
		rst(pmb_pkg::TP_BURST_ONE, pmb_pkg::MODE_MASTER, 1'h0, 1'h1, 1'h1);
		tgt(1'h1, 1'h1, 32'h0000_0300, ok);
		repeat (6) @(posedge clk);
		chk("pf_wr_addr", last_pf, 32'h0000_0300);
		rd(1'h0, 1'h1, 32'h0000_0400);
		chk("np_rd_addr", last_np, 32'h0000_0400);
		pf_slow <= 1'h1;
		b = n_pf;
		tgt(1'h0, 1'h1, 32'h0000_0500, ok);
		tgt(1'h0, 1'h1, 32'h0000_0600, ok);
		repeat (10) @(posedge clk);
		chk("pf_one_pend", n_pf - b, 1);
		pf_slow <= 1'h0;
		rd(1'h1, 1'h0, 32'h0000_0500);
		rd(1'h1, 1'h1, 32'h0000_0600);
		pm_blk <= 1'h1;
		b = n_pm;
		na = 0;
		for (i = 0; i < 10; i++)
		begin
			mst(1'h1, 32'h0000_2000 + i, ok);
			na += ok;
		end
		chk("fifo_fill", na, pmb_pkg::FIFO_DEPTH);
		pm_blk <= 1'h0;
		repeat (40) @(posedge clk);
		chk("pm_wr_cnt", n_pm - b, pmb_pkg::FIFO_DEPTH);
		chk("pm_wr_last", last_pm, 32'h0000_2007);
		mrd(3, 1);
		agent_bus_request_n_in <= 4'hB;
		for (i = 0; i < 60 && agent_bus_grant_n_out !== 4'hB; i++)
			@(negedge clk);
		chk("gnt_two", agent_bus_grant_n_out, 4'hB);
		@(posedge clk);
		agent_bus_request_n_in <= 4'h9;
		repeat (30) @(posedge clk);
		chk("gnt_keep", agent_bus_grant_n_out, 4'hB);
		agent_bus_request_n_in <= 4'hD;
		repeat (30) @(posedge clk);
		chk("gnt_one", agent_bus_grant_n_out, 4'hD);
		agent_bus_request_n_in <= 4'hF;
		repeat (30) @(posedge clk);
		chk("gnt_none", agent_bus_grant_n_out[3:1], 3'h7);
		rst(pmb_pkg::TP_BURST_MULTI, pmb_pkg::MODE_HOST, 1'h1, 1'h1, 1'h1);
		pf_slow <= 1'h1;
		b = n_pf;
		for (i = 0; i < 5; i++)
			tgt(1'h0, 1'h1, 32'h0000_0700 + 4 * i, ok);
		repeat (10) @(posedge clk);
		chk("pf_four_pend", n_pf - b, pmb_pkg::PEND_SLOTS);
		pf_slow <= 1'h0;
		for (i = 0; i < 5; i++)
			rd(1'h1, 1'h0, 32'h0000_0700 + 4 * i);
		mrd(6, 4);
		rst(pmb_pkg::TP_SINGLE, pmb_pkg::MODE_TARGET, 1'h0, 1'h0, 1'h0);
		ic_reset_n_in <= 1'h0;
		repeat (8) @(posedge clk);
		chk("prst_opt_off", periph_reset_n, 1'h1);
		ic_reset_n_in <= 1'h1;
		tgt(1'h1, 1'h0, 32'h0000_0800, ok);
		chk("indep_wr", ok, 1'h1);
		rd(1'h0, 1'h1, 32'h0000_0900);
		conclude();
	end
	initial
	begin
		#150000;
		num_errors++;
		conclude();
	end
endmodule // test_pmb_bridge
